// ==== hw/ssn_core.sv ====
// Contract
// - Unique-ID read shifts out a 64-bit per-part identifier over 64 clocks.
// - Read data changes on falling clock edge; serial input ignored meanwhile.
// - Serial number programs once until reset clears it; later program commands leave it unchanged.
// - Serial-number read outputs the stored 64 bits over the next 64 clocks.
// - An unprogrammed serial number reads back as all zeros.
// - Sector commands ignore the upper 16 address bits, using the low byte.
// - A sector data byte is committed once all 8 bits arrived.
// - Further bytes go to successive addresses; chip select rising ends the write.
// - Sector writes do not wrap past the top; extra bytes are discarded.
// - Sector read outputs one byte per 8 clocks with address auto-increment.
// - Sector reads do not wrap to the lowest address past the top.
// - Fast sector read waits 8 dummy bits after the address before output.
// - Chip select rising ends a sector read and stops output.
// - No program or sector write happens while the write enable latch is clear.
`timescale 1ns/100ps
`default_nettype none
`include "ssn_map.svh"

module ssn_core #(
  parameter logic [7:0] OP_SET_WRITE_ENABLE = 8'h06,
  parameter logic [7:0] OP_CLEAR_WRITE_ENABLE = 8'h04,
  parameter logic [7:0] OP_READ_UNIQUE_ID = 8'h4C,
  // Arbitrary identifier value, replaced per part
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spiSck,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  output logic writeEnableLatch,
  output logic snProgrammed
);
  import ssn_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] sckSync;
  logic [2:0] csNSync;
  logic [1:0] mosiSync;
  logic sckRise;
  logic sckFall;
  logic csRise;
  logic csNow;

  // Stage 0 feeds stage 1 only; edges are found between stages 1 and 2
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sckSync <= 3'h0;
      csNSync <= 3'h7;
      mosiSync <= 2'h0;
    end else begin
      sckSync <= {sckSync[1:0], spiSck};
      csNSync <= {csNSync[1:0], spiCsN};
      mosiSync <= {mosiSync[0], spiMosi};
    end
  end

  assign sckRise = sckSync[1] & ~sckSync[2];
  assign sckFall = ~sckSync[1] & sckSync[2];
  assign csRise = csNSync[1] & ~csNSync[2];
  assign csNow = ~csNSync[1];

  // ==========================================================
  // Special sector array and its write buffer
  logic [7:0] ssMem [0:255];
  logic [15:0] bufData [0:1];
  logic [15:0] bufData0Next;
  logic [15:0] bufData1Next;
  logic bufWrPtrReg;
  logic bufWrPtrNext;
  logic bufRdPtrReg;
  logic bufRdPtrNext;
  logic [1:0] bufCntReg;
  logic [1:0] bufCntNext;
  logic pushValid;
  logic pushReady;
  logic [15:0] pushWord;
  logic popValid;
  logic popReady;
  logic [15:0] popWord;

  // ==========================================================
  // Frame state
  ssn_phase_t phaseReg;
  ssn_phase_t phaseNext;
  ssn_cmd_t cmdReg;
  ssn_cmd_t cmdNext;
  logic [6:0] bitCntReg;
  logic [6:0] bitCntNext;
  logic [63:0] rxReg;
  logic [63:0] rxNext;
  logic [63:0] txReg;
  logic [63:0] txNext;
  logic [8:0] addrReg;
  logic [8:0] addrNext;
  logic welReg;
  logic welNext;
  logic [63:0] snReg;
  logic [63:0] snNext;
  logic snLockReg;
  logic snLockNext;
  logic misoReg;
  logic misoNext;
  logic oeReg;
  logic oeNext;
  logic [63:0] rxShifted;
  logic [7:0] rdByte;

  assign rxShifted = {rxReg[62:0], mosiSync[1]};
  assign pushWord = {addrReg[7:0], rxShifted[7:0]};
  // Past the top the read yields a fixed byte instead of wrapping
  assign rdByte = addrReg[`SSN_SS_PAST_END_BIT] ? `SSN_PAST_END_BYTE : ssMem[addrReg[7:0]];

  // Frame decoding, shifting and output sequencing
  always_comb begin
    phaseNext = phaseReg;
    cmdNext = cmdReg;
    bitCntNext = bitCntReg;
    rxNext = rxReg;
    txNext = txReg;
    addrNext = addrReg;
    welNext = welReg;
    snNext = snReg;
    snLockNext = snLockReg;
    misoNext = misoReg;
    oeNext = oeReg;
    pushValid = 1'b0;
    if (!csNow) begin
      // Deselected: release the output and rearm for the next opcode
      phaseNext = PH_OPCODE;
      cmdNext = CMD_NONE;
      bitCntNext = 7'h00;
      oeNext = 1'b0;
      misoNext = 1'b0;
      if (csRise && (cmdReg == CMD_SN_PROG || cmdReg == CMD_SS_WRITE)) begin
        welNext = 1'b0;
      end
    end else if (sckRise) begin
      case (phaseReg)
        PH_OPCODE: begin
          rxNext = rxShifted;
          bitCntNext = bitCntReg + 7'h01;
          if (bitCntReg == `SSN_LAST_OPC_BIT) begin
            bitCntNext = 7'h00;
            phaseNext = PH_DONE;
            case (rxShifted[7:0])
              OP_SET_WRITE_ENABLE: welNext = 1'b1;
              OP_CLEAR_WRITE_ENABLE: welNext = 1'b0;
              OP_READ_UNIQUE_ID: begin
                cmdNext = CMD_UID;
                txNext = UNIQUE_ID;
                phaseNext = PH_OUT;
              end
              `SSN_OP_FETCH_SN: begin
                cmdNext = CMD_SN_READ;
                txNext = snLockReg ? snReg : `SSN_SN_BLANK;
                phaseNext = PH_OUT;
              end
              `SSN_OP_PROG_SN: begin
                cmdNext = CMD_SN_PROG;
                phaseNext = PH_SN_IN;
              end
              `SSN_OP_SS_WRITE: begin
                cmdNext = CMD_SS_WRITE;
                phaseNext = PH_ADDR;
              end
              `SSN_OP_SS_READ: begin
                cmdNext = CMD_SS_READ;
                phaseNext = PH_ADDR;
              end
              `SSN_OP_SS_FAST: begin
                cmdNext = CMD_SS_FAST;
                phaseNext = PH_ADDR;
              end
              default: phaseNext = PH_DONE;
            endcase
          end
        end
        PH_ADDR: begin
          rxNext = rxShifted;
          bitCntNext = bitCntReg + 7'h01;
          if (bitCntReg == `SSN_LAST_ADDR_BIT) begin
            bitCntNext = 7'h00;
            addrNext = {1'b0, rxShifted[7:0]};
            if (cmdReg == CMD_SS_FAST) begin
              phaseNext = PH_DUMMY;
            end else if (cmdReg == CMD_SS_WRITE) begin
              phaseNext = PH_SS_IN;
            end else begin
              phaseNext = PH_OUT;
            end
          end
        end
        PH_DUMMY: begin
          bitCntNext = bitCntReg + 7'h01;
          if (bitCntReg == `SSN_LAST_DUMMY_BIT) begin
            bitCntNext = 7'h00;
            phaseNext = PH_OUT;
          end
        end
        PH_SN_IN: begin
          rxNext = rxShifted;
          bitCntNext = bitCntReg + 7'h01;
          if (bitCntReg == `SSN_LAST_SN_BIT) begin
            phaseNext = PH_DONE;
            // One-time region: locked after the first accepted program
            if (welReg && !snLockReg) begin
              snNext = rxShifted;
              snLockNext = 1'b1;
            end
          end
        end
        PH_SS_IN: begin
          rxNext = rxShifted;
          bitCntNext = {4'h0, bitCntReg[2:0] + 3'h1};
          if (bitCntReg[2:0] == `SSN_LAST_BYTE_BIT) begin
            // Whole byte in: hand it to the buffer, stop at the top
            if (!addrReg[`SSN_SS_PAST_END_BIT]) begin
              pushValid = welReg;
              addrNext = addrReg + 9'h001;
            end
          end
        end
        default: begin
          // Output and finished phases ignore serial input
          phaseNext = phaseReg;
        end
      endcase
    end else if (sckFall && phaseReg == PH_OUT) begin
      oeNext = 1'b1;
      if (cmdReg == CMD_SS_READ || cmdReg == CMD_SS_FAST) begin
        bitCntNext = {4'h0, bitCntReg[2:0] + 3'h1};
        if (bitCntReg[2:0] == `SSN_FIRST_BYTE_BIT) begin
          misoNext = rdByte[7];
          txNext = {rdByte[6:0], 57'h0};
          if (!addrReg[`SSN_SS_PAST_END_BIT]) begin
            addrNext = addrReg + 9'h001;
          end
        end else begin
          misoNext = txReg[63];
          txNext = {txReg[62:0], 1'b0};
        end
      end else begin
        misoNext = txReg[63];
        txNext = {txReg[62:0], 1'b0};
      end
    end
  end

  // Serial number and latch are plain flops here; storage retention is outside
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phaseReg <= PH_OPCODE;
      cmdReg <= CMD_NONE;
      bitCntReg <= 7'h00;
      rxReg <= 64'h0;
      txReg <= 64'h0;
      addrReg <= 9'h000;
      welReg <= 1'b0;
      snReg <= `SSN_SN_BLANK;
      snLockReg <= 1'b0;
      misoReg <= 1'b0;
      oeReg <= 1'b0;
    end else begin
      phaseReg <= phaseNext;
      cmdReg <= cmdNext;
      bitCntReg <= bitCntNext;
      rxReg <= rxNext;
      txReg <= txNext;
      addrReg <= addrNext;
      welReg <= welNext;
      snReg <= snNext;
      snLockReg <= snLockNext;
      misoReg <= misoNext;
      oeReg <= oeNext;
    end
  end

  // ==========================================================
  // Two-entry write buffer; the array port yields to sector reads
  assign pushReady = (bufCntReg != `SSN_BUF_FULL);
  assign popValid = (bufCntReg != `SSN_BUF_EMPTY);
  assign popReady = (phaseReg != PH_OUT);
  assign popWord = bufData[bufRdPtrReg];

  always_comb begin
    bufWrPtrNext = bufWrPtrReg;
    bufRdPtrNext = bufRdPtrReg;
    bufData0Next = bufData[0];
    bufData1Next = bufData[1];
    if (pushValid && pushReady) begin
      bufWrPtrNext = ~bufWrPtrReg;
      if (bufWrPtrReg) begin
        bufData1Next = pushWord;
      end else begin
        bufData0Next = pushWord;
      end
    end
    if (popValid && popReady) begin
      bufRdPtrNext = ~bufRdPtrReg;
    end
    bufCntNext = bufCntReg + {1'b0, pushValid && pushReady} - {1'b0, popValid && popReady};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bufWrPtrReg <= 1'b0;
      bufRdPtrReg <= 1'b0;
      bufCntReg <= 2'h0;
      bufData[0] <= 16'h0000;
      bufData[1] <= 16'h0000;
    end else begin
      bufWrPtrReg <= bufWrPtrNext;
      bufRdPtrReg <= bufRdPtrNext;
      bufCntReg <= bufCntNext;
      bufData[0] <= bufData0Next;
      bufData[1] <= bufData1Next;
    end
  end

  // Array write port; contents survive reset as nonvolatile cells would
  always_ff @(posedge sys_clk) begin
    if (popValid && popReady) begin
      ssMem[popWord[15:8]] <= popWord[7:0];
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign spiMiso = misoReg;
  assign spiMisoOe = oeReg;
  assign writeEnableLatch = welReg;
  assign snProgrammed = snLockReg;

endmodule : ssn_core
`default_nettype wire

// ==== hw/ssn_map.svh ====
`ifndef SSN_MAP_SVH
`define SSN_MAP_SVH

// ==========================================================
// Command opcodes
`define SSN_OP_PROG_SN 8'hC2
`define SSN_OP_FETCH_SN 8'hC3
`define SSN_OP_SS_WRITE 8'h42
`define SSN_OP_SS_READ 8'h4B
`define SSN_OP_SS_FAST 8'h49

// ==========================================================
// Frame phase lengths, as the index of the last bit of each phase, and the first bit of a byte
`define SSN_LAST_OPC_BIT 7'h07
`define SSN_LAST_ADDR_BIT 7'h17
`define SSN_LAST_DUMMY_BIT 7'h07
`define SSN_LAST_SN_BIT 7'h3F
`define SSN_LAST_BYTE_BIT 3'h7
`define SSN_FIRST_BYTE_BIT 3'h0

// ==========================================================
// Special sector geometry and blank values
`define SSN_SS_PAST_END_BIT 8
`define SSN_SN_BLANK 64'h0000000000000000
`define SSN_PAST_END_BYTE 8'h00

// ==========================================================
// Write buffer in front of the special sector array
`define SSN_BUF_FULL 2'h2
`define SSN_BUF_EMPTY 2'h0

`endif

// ==== hw/ssn_pkg.sv ====
package ssn_pkg;

  // Frame phase of the serial target
  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR, PH_DUMMY, PH_SN_IN, PH_SS_IN, PH_OUT, PH_DONE
  } ssn_phase_t;

  // Command in progress within the current frame
  typedef enum logic [2:0] {
    CMD_NONE, CMD_UID, CMD_SN_READ, CMD_SN_PROG, CMD_SS_WRITE, CMD_SS_READ, CMD_SS_FAST
  } ssn_cmd_t;

endpackage : ssn_pkg

// ==== dv/ssn_core_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checks for the serial target
module ssn_core_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spiSck,
  input wire logic spiCsN,
  input wire logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  input wire logic writeEnableLatch,
  input wire logic snProgrammed
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Five cycles high outlast the chip-select synchroniser
  idle_hiz_a: assert property (spiCsN [*5] |-> !spiMisoOe)
    else $error("output driven while deselected");
  fall_shift_a: assert property (spiMisoOe && $past(spiMisoOe) && $changed(spiMiso) |->
    !$past(spiSck, 3)) else $error("output bit changed away from a falling clock");
  oe_start_a: assert property ($rose(spiMisoOe) |-> !spiCsN && !$past(spiSck, 3))
    else $error("output enabled outside a data phase");
  oe_hold_a: assert property (spiMisoOe && !spiCsN |=> spiMisoOe)
    else $error("output dropped while still selected");
  oe_stop_a: assert property ($fell(spiMisoOe) |-> $past(spiCsN, 2))
    else $error("output released without a deselect");
  sn_lock_a: assert property (snProgrammed |=> snProgrammed)
    else $error("serial number lock was lost");
  sn_wel_a: assert property ($rose(snProgrammed) |-> $past(writeEnableLatch) && !spiCsN)
    else $error("serial number stored without write enable");
  wel_set_a: assert property ($rose(writeEnableLatch) |-> !spiCsN && $past(spiSck, 2))
    else $error("write enable set away from a clock rise");
endmodule : ssn_core_props

bind ssn_core ssn_core_props i_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .spiSck(spiSck),
  .spiCsN(spiCsN),
  .spiMosi(spiMosi),
  .spiMiso(spiMiso),
  .spiMisoOe(spiMisoOe),
  .writeEnableLatch(writeEnableLatch),
  .snProgrammed(snProgrammed)
);
`default_nettype wire

// ==== dv/ssn_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Serial host, mode 0, clock period of eight system clocks
module ssn_host_model (
  input wire logic sys_clk,
  output logic spiSck,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe
);
  logic [63:0] rxBits;
  logic oeBad;

  // Link clock idles low between frames
  initial begin
    spiSck = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
    rxBits = 64'h0;
    oeBad = 1'b0;
  end

  // Shifts MSB first; in read bits the input toggles since it must be ignored
  task automatic shift(input logic [63:0] d, input int n, input bit rd);
    for (int i = n - 1; i >= 0; i--) begin
      spiMosi <= rd ? ~spiMosi : d[i];
      repeat (4) @(posedge sys_clk);
      spiSck <= 1'b1;
      // A released output reads as the inverse, so a missing enable cannot pass
      rxBits <= {rxBits[62:0], spiMisoOe ? spiMiso : ~spiMiso};
      oeBad <= oeBad | (rd ^ spiMisoOe);
      repeat (4) @(posedge sys_clk);
      spiSck <= 1'b0;
    end
  endtask : shift

  // One command per frame; write enable is its own earlier frame, and
  // the fast read argument already carries its dummy byte
  task automatic frame(input logic [7:0] op, input logic [63:0] arg, input int nArg,
                       input int nRd);
    @(posedge sys_clk);
    spiCsN <= 1'b0;
    oeBad <= 1'b0;
    repeat (4) @(posedge sys_clk);
    shift({56'h0, op}, 8, 1'b0);
    shift(arg, nArg, 1'b0);
    shift(64'h0, nRd, 1'b1);
    repeat (4) @(posedge sys_clk);
    spiCsN <= 1'b1;
    spiMosi <= ~spiMosi;
    repeat (8) @(posedge sys_clk);
  endtask : frame
endmodule : ssn_host_model
`default_nettype wire

// ==== dv/tb_spi_id_serial_special_sector.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ssn_map.svh"
// ==========================================================
// Bench top
module tb_spi_id_serial_special_sector;
  localparam logic [63:0] ID_VALUE = 64'h0F1E2D3C4B5A6978; // Arbitrary value
  localparam logic [7:0] OP_WEL = 8'h06;
  localparam logic [7:0] OP_WEL_CLR = 8'h04;
  localparam logic [7:0] OP_UID = 8'h4C;
  localparam logic [63:0] SN_A = 64'hA5C3_0011_8E7F_4D21;
  logic sys_clk;
  logic rst;
  logic spiSck;
  logic spiCsN;
  logic spiMosi;
  logic spiMiso;
  logic spiMisoOe;
  logic writeEnableLatch;
  logic snProgrammed;
  int miscompares = 0;
  int samplesChecked = 0;

  ssn_core #(.OP_SET_WRITE_ENABLE(OP_WEL), .OP_CLEAR_WRITE_ENABLE(OP_WEL_CLR),
    .OP_READ_UNIQUE_ID(OP_UID), .UNIQUE_ID(ID_VALUE)) i_dut (.sys_clk(sys_clk),
    .rst(rst), .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .writeEnableLatch(writeEnableLatch), .snProgrammed(snProgrammed));
  ssn_host_model i_host (.sys_clk(sys_clk), .spiSck(spiSck), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe));

  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Compared %0d, mismatched %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic test_uid();
    i_host.frame(OP_UID, 64'h0, 0, 64);
    check(i_host.rxBits, ID_VALUE);
    check({63'h0, i_host.oeBad}, 64'h0);
  endtask : test_uid

  // Blank read, refused program, one program, then a locked second try
  task automatic test_serial();
    i_host.frame(`SSN_OP_FETCH_SN, 64'h0, 0, 64);
    check(i_host.rxBits, `SSN_SN_BLANK);
    i_host.frame(`SSN_OP_PROG_SN, SN_A, 64, 0);
    check({63'h0, snProgrammed}, 64'h0);
    // Latch set then cleared again must still refuse the program
    i_host.frame(OP_WEL, 64'h0, 0, 0);
    i_host.frame(OP_WEL_CLR, 64'h0, 0, 0);
    check({63'h0, writeEnableLatch}, 64'h0);
    i_host.frame(`SSN_OP_PROG_SN, SN_A, 64, 0);
    check({63'h0, snProgrammed}, 64'h0);
    i_host.frame(OP_WEL, 64'h0, 0, 0);
    check({63'h0, writeEnableLatch}, 64'h1);
    i_host.frame(`SSN_OP_PROG_SN, SN_A, 64, 0);
    check({63'h0, snProgrammed}, 64'h1);
    i_host.frame(OP_WEL, 64'h0, 0, 0);
    i_host.frame(`SSN_OP_PROG_SN, ~SN_A, 64, 0);
    i_host.frame(`SSN_OP_FETCH_SN, 64'h0, 0, 64);
    check(i_host.rxBits, SN_A);
  endtask : test_serial

  // Writes at the bottom and near the top, a partial byte, a refused write, then both reads
  task automatic test_sector();
    i_host.frame(OP_WEL, 64'h0, 0, 0);
    i_host.frame(`SSN_OP_SS_WRITE, {16'h0, 24'h123400, 24'h6C5AA5}, 48, 0);
    i_host.frame(OP_WEL, 64'h0, 0, 0);
    i_host.frame(`SSN_OP_SS_WRITE, {16'h0, 24'hFFFFFE, 24'h112233}, 48, 0);
    check({63'h0, writeEnableLatch}, 64'h0);
    i_host.frame(OP_WEL, 64'h0, 0, 0);
    i_host.frame(`SSN_OP_SS_WRITE, {28'h0, 24'h000001, 8'hC3, 4'hF}, 36, 0);
    i_host.frame(`SSN_OP_SS_WRITE, {32'h0, 24'h000002, 8'h77}, 32, 0);
    i_host.frame(`SSN_OP_SS_READ, {40'h0, 24'hABCDFE}, 24, 32);
    check({32'h0, i_host.rxBits[31:0]}, 64'h11220000);
    // Byte 00 would hold the dropped 33 if the top write wrapped
    i_host.frame(`SSN_OP_SS_FAST, {32'h0, 24'h5A5A00, 8'h00}, 32, 24);
    check({40'h0, i_host.rxBits[23:0]}, 64'h6CC3A5);
    check({63'h0, i_host.oeBad}, 64'h0);
  endtask : test_sector

  // Reset in mid-run drops the lock, the latch and the output enable
  task automatic test_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({61'h0, snProgrammed, writeEnableLatch, spiMisoOe}, 64'h0);
    i_host.frame(`SSN_OP_FETCH_SN, 64'h0, 0, 64);
    check(i_host.rxBits, `SSN_SN_BLANK);
  endtask : test_reset

  // Reset held three cycles, then the scenarios
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    test_uid();
    test_serial();
    test_reset();
    test_sector();
    complete_run();
  end

  // 21 frames of under 100 bits at 160 ns take under 350 us; allow 500 us
  initial begin
    #500000;
    miscompares++;
    complete_run();
  end
endmodule : tb_spi_id_serial_special_sector
`default_nettype wire
